// file: shared/spm_pkg.sv
// Purpose: Shared constants and types for the sector protection map block
// Assumes: Core clock of 25 MHz; serial link in SPI mode 0 or 3
// Notes:   Opcodes, map layout and self-timed cycle lengths live here only
package spm_pkg;

    // ***************************************************************
    // Map layout
    // ***************************************************************
    localparam int          MAP_BYTES       = 16;
    localparam int          MAP_IDX_W       = 4;
    localparam logic [7:0]  MAP_RESET_BYTE  = 8'h00;
    localparam logic [7:0]  MAP_ERASED_BYTE = 8'hFF;
    localparam logic [7:0]  MAP_UNDEF_BYTE  = 8'h00;
    localparam int          SUB0A_BIT       = 7;
    localparam int          SUB0B_BIT       = 5;
    localparam int          SECT_BIT        = 7;

    typedef logic [MAP_BYTES-1:0][7:0] map_type;

    // ***************************************************************
    // Command bytes
    // ***************************************************************
    localparam logic [7:0]  PREFIX_0        = 8'h3D;
    localparam logic [7:0]  PREFIX_1        = 8'h2A;
    localparam logic [7:0]  PREFIX_2        = 8'h7F;
    localparam logic [7:0]  OP_MAP_ERASE    = 8'hCF;
    localparam logic [7:0]  OP_MAP_PROGRAM  = 8'hFC;
    localparam logic [7:0]  OP_MAP_READ     = 8'h32;
    localparam logic [7:0]  OP_STATUS_READ  = 8'hD7;
    localparam logic [2:0]  HDR_BYTES       = 3'h4;
    localparam logic [5:0]  READ_DUMMIES    = 6'h03;

    // ***************************************************************
    // Status byte fields
    // ***************************************************************
    localparam int          STAT_READY_BIT  = 7;
    localparam int          STAT_PROT_BIT   = 1;

    // ***************************************************************
    // Self-timed cycles
    // ***************************************************************
    localparam int          CLOCK_MHZ           = 25;
    localparam int          MAP_ERASE_TIME_US   = 2000;
    localparam int          MAP_PROGRAM_TIME_US = 1000;
    localparam int          MAP_ERASE_CYCLES    = MAP_ERASE_TIME_US * CLOCK_MHZ;
    localparam int          MAP_PROGRAM_CYCLES  = MAP_PROGRAM_TIME_US * CLOCK_MHZ;

    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_ERASE,
        CYC_PROGRAM
    } cycle_type;

endpackage : spm_pkg

// file: core/bit_sync.sv
// Purpose: Two-flop synchroniser for level signals
// Assumes: Inputs change slowly against the sampling clock
// Notes:   Only the second stage leaves this module
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_type;

    sync_state_type q;
    sync_state_type d;

    always_comb begin
        d        = q;
        d.stage1 = async_in;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    assign sync_out = q.stage2;

endmodule : bit_sync

// file: core/spi_link.sv
// Purpose: Serial link front end on the host's serial clock
// Assumes: Host samples output on the rising edge; select frames every transfer
// Notes:   Frame state is cleared by select itself, since the clock stops between frames
module spi_link (
    input  wire logic            sck,
    input  wire logic            rst,
    input  wire logic            cs_n,
    input  wire logic            si,
    input  wire spm_pkg::map_type map_in,
    input  wire logic            busy,
    input  wire logic            prot_active,
    output logic                 so_q,
    output logic                 so_oe_q,
    output logic                 rx_tog_q,
    output logic [7:0]           rx_byte_q
);

    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [7:0] shift_in;
        logic [5:0] byte_cnt;
        logic [7:0] opcode;
        logic [7:0] tx;
        logic       so;
        logic       so_oe;
    } frame_state_type;

    typedef struct packed {
        logic       tog;
        logic [7:0] data;
    } xfer_state_type;

    frame_state_type q;
    frame_state_type d;
    xfer_state_type  xq;
    xfer_state_type  xd;
    logic [1:0]      stat_s;
    logic [7:0]      byte_now;
    logic [7:0]      opc;
    logic            done;

    // Busy and protection cross as levels; the first status byte comes 8 edges later
    bit_sync #(.WIDTH(2)) u_stat_sync (
        .clock    (sck),
        .async_in ({busy, prot_active}),
        .sync_out (stat_s)
    );

    function automatic logic [7:0] map_byte(input spm_pkg::map_type m, input logic [5:0] idx);
        if (idx < 6'(spm_pkg::MAP_BYTES)) begin
            map_byte = m[idx[3:0]];
        end else begin
            map_byte = spm_pkg::MAP_UNDEF_BYTE; // see R18
        end
    endfunction : map_byte

    function automatic logic [7:0] status_byte(input logic bsy, input logic prot);
        status_byte                         = 8'h00;
        status_byte[spm_pkg::STAT_READY_BIT] = ~bsy;
        status_byte[spm_pkg::STAT_PROT_BIT]  = prot;
    endfunction : status_byte

    always_comb begin
        logic [7:0] nb;
        nb         = 8'h00;
        d          = q;
        byte_now   = {q.shift_in[6:0], si};
        done       = (q.bit_cnt == 3'h7);
        opc        = (q.byte_cnt == 6'h00) ? byte_now : q.opcode;
        d.shift_in = byte_now;
        d.bit_cnt  = q.bit_cnt + 3'h1;
        if (done && q.byte_cnt == 6'h00) begin
            d.opcode = byte_now;
        end
        if (done && q.byte_cnt != 6'h3F) begin
            d.byte_cnt = q.byte_cnt + 6'h01;
        end
        if (done && opc == spm_pkg::OP_MAP_READ && q.byte_cnt >= spm_pkg::READ_DUMMIES) begin
            nb      = map_byte(map_in, q.byte_cnt - spm_pkg::READ_DUMMIES); // see R17
            d.so    = nb[7];
            d.tx    = {nb[6:0], 1'b0};
            d.so_oe = 1'b1;
        end else if (done && opc == spm_pkg::OP_STATUS_READ) begin
            nb      = status_byte(stat_s[1], stat_s[0]); // see R22
            d.so    = nb[7];
            d.tx    = {nb[6:0], 1'b0};
            d.so_oe = 1'b1;
        end else if (q.so_oe) begin
            d.so    = q.tx[7];
            d.tx    = {q.tx[6:0], 1'b0};
        end
        xd = xq;
        if (done) begin
            xd.tog  = ~xq.tog;
            xd.data = byte_now;
        end
    end

    // Raising select clears the frame at once and floats the output
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            q <= '0; // see R19
        end else begin
            q <= d;
        end
    end

    // Byte handoff must survive frame ends, so only the core reset clears it
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            xq <= '0;
        end else begin
            xq <= xd;
        end
    end

    assign so_q      = q.so;
    assign so_oe_q   = q.so_oe;
    assign rx_tog_q  = xq.tog;
    assign rx_byte_q = xq.data;

endmodule : spi_link

// file: core/sector_protect_map.sv
// Purpose: Command handling for the nonvolatile sector protection map
// Assumes: Host is an SPI master; sck is a separate, unrelated clock
// Notes:   Map sits in flops; reset stands for the delivered state
//
// Contract
// R1: Sixteen map bytes, one per sector
// R2: Map must be erased before programming
// R3: Sectors 1-15: FFh protects, 00h unprotects
// R4: Sector 0 byte: 7:6 sub 0a, 5:4 sub 0b
// R5: Delivered map holds 00h everywhere
// R6: Erase sequence, then select release starts erase
// R7: Busy reported during map erase cycle
// R8: Erase sets FFh; blocks program and erase
// R9: Erase accepted whether protection on or off
// R10: Program sequence, 16 bytes, release starts program
// R11: Busy reported during map program cycle
// R12: Seventeenth data byte wraps to position zero
// R13: Host sends all sixteen data bytes
// R14: Host sends only valid map values
// R15: Program accepted whether protection on or off
// R16: Program command overwrites data buffer one
// R17: Read: opcode, three dummies, bytes 0 to 15
// R18: Bytes after the sixteenth are undefined
// R19: Select release ends read, output floats
// R20: Host limits map rewrites below 10,000
// R21: Write protect pin blocks map changes
// R22: Status opcode streams ready and busy
// R23: Partial command sequence starts nothing
module sector_protect_map #(
    parameter int ERASE_CYCLES   = spm_pkg::MAP_ERASE_CYCLES,
    parameter int PROGRAM_CYCLES = spm_pkg::MAP_PROGRAM_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        si,
    input  wire logic        wp_n,
    input  wire logic        prot_en,
    output logic             so_q,
    output logic             so_oe_q,
    output logic             busy_q,
    output logic             buf1_wr_q,
    output logic [3:0]       buf1_addr_q,
    output logic [7:0]       buf1_data_q,
    output logic             sub0a_prot_q,
    output logic             sub0b_prot_q,
    output logic [15:0]      sect_prot_q
);

    localparam int CNT_W = $clog2(ERASE_CYCLES > PROGRAM_CYCLES ?
                                  ERASE_CYCLES : PROGRAM_CYCLES) + 1;

    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        logic                        cs_prev;
        logic                        tog_prev;
        spm_pkg::cycle_type          state;
        logic [CNT_W-1:0]            cnt;
        spm_pkg::map_type            map;
        spm_pkg::map_type            stage;
        logic [2:0]                  hdr_cnt;
        logic                        hdr_ok;
        logic                        is_erase;
        logic                        is_prog;
        logic [spm_pkg::MAP_IDX_W-1:0] ptr;
        logic                        buf1_wr;
        logic [3:0]                  buf1_addr;
        logic [7:0]                  buf1_data;
        logic                        busy;
        logic                        sub0a;
        logic                        sub0b;
        logic [15:0]                 sect;
    } core_state_type;

    core_state_type q;
    core_state_type d;
    logic [2:0]     sync_s;
    logic           cs_s;
    logic           wp_on;
    logic           tog_s;
    logic           rx_tog;
    logic [7:0]     rx_byte;
    logic           cs_fall;
    logic           cs_rise;
    logic           rx_evt;
    logic           active;
    logic           start_erase;
    logic           start_prog;
    logic           data_wr;

    // ***************************************************************
    // Link side and crossings
    // ***************************************************************
    // Map is handed over quasi-static: it only changes at the end of an erase or program cycle
    spi_link u_link (
        .sck         (sck),
        .rst         (rst),
        .cs_n        (cs_n),
        .si          (si),
        .map_in      (q.map),
        .busy        (q.busy),
        .prot_active (active),
        .so_q        (so_q),
        .so_oe_q     (so_oe_q),
        .rx_tog_q    (rx_tog),
        .rx_byte_q   (rx_byte)
    );

    bit_sync #(.WIDTH(3)) u_sync (
        .clock    (clock),
        .async_in ({cs_n, wp_n, rx_tog}),
        .sync_out (sync_s)
    );

    assign cs_s    = sync_s[2];
    assign wp_on   = ~sync_s[1];
    assign tog_s   = sync_s[0];
    assign cs_fall = q.cs_prev & ~cs_s;
    assign cs_rise = ~q.cs_prev & cs_s;
    assign rx_evt  = tog_s ^ q.tog_prev;
    // Pin overrides software protection for the sectors
    assign active  = prot_en | wp_on;

    function automatic logic [7:0] prefix_byte(input logic [2:0] idx);
        unique case (idx)
            3'h0:    prefix_byte = spm_pkg::PREFIX_0;
            3'h1:    prefix_byte = spm_pkg::PREFIX_1;
            default: prefix_byte = spm_pkg::PREFIX_2;
        endcase
    endfunction : prefix_byte

    // ***************************************************************
    // Command decode and self-timed cycles
    // ***************************************************************
    always_comb begin
        d           = q;
        start_erase = 1'b0;
        start_prog  = 1'b0;
        data_wr     = 1'b0;
        d.cs_prev   = cs_s;
        d.tog_prev  = tog_s;
        d.buf1_wr   = 1'b0;

        if (cs_fall) begin
            d.hdr_cnt  = 3'h0;
            d.hdr_ok   = (q.state == spm_pkg::CYC_IDLE);
            d.is_erase = 1'b0;
            d.is_prog  = 1'b0;
        end

        // Byte handoff is taken after a select fall and before a select rise of the same cycle
        if (rx_evt) begin
            if (d.hdr_cnt < spm_pkg::HDR_BYTES - 3'h1) begin
                if (rx_byte != prefix_byte(d.hdr_cnt)) begin
                    d.hdr_ok = 1'b0;
                end
                d.hdr_cnt = d.hdr_cnt + 3'h1;
            end else if (d.hdr_cnt == spm_pkg::HDR_BYTES - 3'h1) begin
                d.is_erase = (rx_byte == spm_pkg::OP_MAP_ERASE);
                d.is_prog  = (rx_byte == spm_pkg::OP_MAP_PROGRAM);
                if (!d.is_erase && !d.is_prog) begin
                    d.hdr_ok = 1'b0;
                end
                d.ptr     = '0;
                d.hdr_cnt = spm_pkg::HDR_BYTES;
            end else if (d.hdr_ok && d.is_prog) begin
                data_wr                = 1'b1;
                d.stage[d.ptr]         = rx_byte;
                d.buf1_wr              = 1'b1; // see R16
                d.buf1_addr            = d.ptr;
                d.buf1_data            = rx_byte;
                d.ptr                  = d.ptr + 4'h1; // see R12
            end
        end

        // Incomplete headers and a held write-protect pin start nothing
        if (cs_rise && d.hdr_ok && d.hdr_cnt == spm_pkg::HDR_BYTES && !wp_on // see R23
            && q.state == spm_pkg::CYC_IDLE) begin // see R21
            if (d.is_erase) begin
                start_erase = 1'b1; // see R6
                d.state     = spm_pkg::CYC_ERASE; // see R9
                d.cnt       = CNT_W'(ERASE_CYCLES - 1);
            end else if (d.is_prog) begin
                start_prog  = 1'b1; // see R10
                d.state     = spm_pkg::CYC_PROGRAM; // see R15
                d.cnt       = CNT_W'(PROGRAM_CYCLES - 1);
            end
        end
        if (cs_rise) begin
            d.hdr_ok = 1'b0;
        end

        unique case (q.state)
            spm_pkg::CYC_IDLE: begin
            end
            spm_pkg::CYC_ERASE: begin
                if (q.cnt == '0) begin
                    for (int i = 0; i < spm_pkg::MAP_BYTES; i++) begin
                        d.map[i] = spm_pkg::MAP_ERASED_BYTE; // see R8
                    end
                    d.state = spm_pkg::CYC_IDLE;
                end else begin
                    d.cnt = q.cnt - CNT_W'(1);
                end
            end
            spm_pkg::CYC_PROGRAM: begin
                if (q.cnt == '0) begin
                    // Programming only clears bits, hence the erase beforehand
                    d.map   = q.map & q.stage; // see R2
                    d.state = spm_pkg::CYC_IDLE;
                end else begin
                    d.cnt = q.cnt - CNT_W'(1);
                end
            end
        endcase

        d.busy  = (d.state != spm_pkg::CYC_IDLE); // see R7 // see R11
        d.sub0a = active & d.map[0][spm_pkg::SUB0A_BIT]; // see R4
        d.sub0b = active & d.map[0][spm_pkg::SUB0B_BIT];
        d.sect[0] = d.sub0a | d.sub0b;
        for (int n = 1; n < spm_pkg::MAP_BYTES; n++) begin
            d.sect[n] = active & d.map[n][spm_pkg::SECT_BIT]; // see R3 // see R1
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q         <= '0;
            q.cs_prev <= 1'b1;
            for (int i = 0; i < spm_pkg::MAP_BYTES; i++) begin
                q.map[i] <= spm_pkg::MAP_RESET_BYTE; // see R5
            end
        end else begin
            q <= d;
        end
    end

    assign busy_q       = q.busy;
    assign buf1_wr_q    = q.buf1_wr;
    assign buf1_addr_q  = q.buf1_addr;
    assign buf1_data_q  = q.buf1_data;
    assign sub0a_prot_q = q.sub0a;
    assign sub0b_prot_q = q.sub0b;
    assign sect_prot_q  = q.sect;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    property p_reset_map;
        @(posedge clock) disable iff (rst)
        $past(rst) |-> (q.map == '0);
    endproperty
    a_reset_map: assert property (p_reset_map) // see R5
        else $error("map not cleared after reset");

    property p_erase_start;
        @(posedge clock) disable iff (rst)
        start_erase |=> (q.state == spm_pkg::CYC_ERASE) ##0 busy_q [*8];
    endproperty
    a_erase_start: assert property (p_erase_start) // see R7
        else $error("erase cycle did not start busy");

    property p_prog_start;
        @(posedge clock) disable iff (rst)
        start_prog |=> (q.state == spm_pkg::CYC_PROGRAM) ##0 busy_q [*8];
    endproperty
    a_prog_start: assert property (p_prog_start) // see R11
        else $error("program cycle did not start busy");

    property p_erase_result;
        @(posedge clock) disable iff (rst)
        (q.state == spm_pkg::CYC_ERASE && q.cnt == '0) |=> (&q.map) && !busy_q;
    endproperty
    a_erase_result: assert property (p_erase_result) // see R8
        else $error("erase did not set every map byte");

    property p_partial_ignored;
        @(posedge clock) disable iff (rst)
        (cs_rise && !rx_evt && q.hdr_cnt != spm_pkg::HDR_BYTES
         && q.state == spm_pkg::CYC_IDLE) |=> (q.state == spm_pkg::CYC_IDLE);
    endproperty
    a_partial_ignored: assert property (p_partial_ignored) // see R23
        else $error("partial command started a cycle");

    property p_wp_blocks;
        @(posedge clock) disable iff (rst)
        (cs_rise && wp_on && q.state == spm_pkg::CYC_IDLE) |=> !busy_q;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) // see R21
        else $error("map changed with write protect held");

    property p_ptr_wrap;
        @(posedge clock) disable iff (rst)
        (data_wr && q.ptr == 4'hF) |=> (q.ptr == 4'h0);
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) // see R12
        else $error("data pointer did not wrap");

    property p_buf1_write;
        @(posedge clock) disable iff (rst)
        data_wr |=> buf1_wr_q && buf1_addr_q == $past(q.ptr) && buf1_data_q == $past(rx_byte);
    endproperty
    a_buf1_write: assert property (p_buf1_write) // see R16
        else $error("buffer one write missing");

    property p_sub0a;
        @(posedge clock) disable iff (rst)
        (q.state == spm_pkg::CYC_IDLE && prot_en && q.map[0][7:6] == 2'b11)
            |-> sub0a_prot_q && sect_prot_q[0];
    endproperty
    a_sub0a: assert property (p_sub0a) // see R4
        else $error("sub-sector 0a not protected");

    property p_sect_open;
        @(posedge clock) disable iff (rst)
        (q.state == spm_pkg::CYC_IDLE && q.map[3] == 8'h00) |=> !sect_prot_q[3];
    endproperty
    a_sect_open: assert property (p_sect_open) // see R3
        else $error("sector with 00h reported protected");

    property p_sub0b;
        @(posedge clock) disable iff (rst)
        (q.state == spm_pkg::CYC_IDLE && prot_en && q.map[0][5:4] == 2'b11)
            |-> sub0b_prot_q && sect_prot_q[0];
    endproperty
    a_sub0b: assert property (p_sub0b) // see R4
        else $error("sub-sector 0b not protected");

    property p_sect_guard;
        @(posedge clock) disable iff (rst)
        (q.state == spm_pkg::CYC_IDLE && prot_en && q.map[5] == 8'hFF)
            |-> sect_prot_q[5];
    endproperty
    a_sect_guard: assert property (p_sect_guard) // see R3
        else $error("sector with FFh not protected");

    // Program may only clear bits, so the result is the old map masked by the data
    property p_prog_result;
        @(posedge clock) disable iff (rst)
        (q.state == spm_pkg::CYC_PROGRAM && q.cnt == '0)
            |=> (q.map == ($past(q.map) & $past(q.stage))) && !busy_q;
    endproperty
    a_prog_result: assert property (p_prog_result) // see R2
        else $error("program did not merge data into map");

endmodule : sector_protect_map

// file: bench/spi_host.sv
// Purpose: Behavioural SPI host that frames map commands for the bench
// Assumes: Mode 0; serial clock period 125 ns, held low between frames
// Notes:   Read bits are taken just before each rising edge, because the
//          device presents a bit on the edge before
module spi_host (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so_q,
    input  wire logic so_oe_q
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sck  = 1'b0;
        cs_n = 1'b0;
        si   = 1'b0;
        // A true select edge clears the link frame state before the first frame
        #1 cs_n = 1'b1;
    end

    // ***************************************************************
    // Framing and byte transfer
    // ***************************************************************
    task open_frame();
        cs_n = 1'b0;
        #62.5;
    endtask : open_frame

    // Idle gap lets the core see select high before the next frame
    task close_frame();
        #62.5;
        cs_n = 1'b1;
        si   = ~si;
        #400;
    endtask : close_frame

    task put(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #62.5;
            rx[i] = so_oe_q ? so_q : 1'bx;
            sck = 1'b1;
            #62.5;
            sck = 1'b0;
        end
    endtask : put

    // ***************************************************************
    // Commands
    // ***************************************************************
    task map_cmd(input logic [7:0] op, input int n, input logic [7:0] d [17]);
        logic [7:0] rx;
        open_frame();
        put(spm_pkg::PREFIX_0, rx);
        put(spm_pkg::PREFIX_1, rx);
        put(spm_pkg::PREFIX_2, rx);
        put(op, rx);
        for (int k = 0; k < n; k++) put(d[k], rx);
        close_frame();
    endtask : map_cmd

    task rd(input logic [7:0] op, input int dummies, input int n, output logic [7:0] r [17]);
        logic [7:0] rx;
        open_frame();
        put(op, rx);
        for (int k = 0; k < dummies; k++) put(8'hA5, rx);
        for (int k = 0; k < n; k++) put(8'h00, r[k]);
        close_frame();
    endtask : rd
endmodule : spi_host

// file: bench/tb.sv
// Purpose: Self-checking bench for the sector protection map block
// Assumes: Short self-timed cycles; few map rewrites per run
// Notes:   Busy length and buffer writes are tracked by a monitor process
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int ERASE_C = 200;
    localparam int PROG_C  = 120;
    logic        clock, rst, sck, cs_n, si, wp_n, prot_en, busy_seen;
    logic        so_q, so_oe_q, busy_q, buf1_wr_q, sub0a_prot_q, sub0b_prot_q;
    logic [3:0]  buf1_addr_q, wr_addr;
    logic [7:0]  buf1_data_q, wr_data;
    logic [15:0] sect_prot_q;
    logic [7:0]  r [17];
    logic [7:0]  d [17];
    int          error_cnt, tests_run, run, last_run, wr_cnt;

    sector_protect_map #(.ERASE_CYCLES(ERASE_C), .PROGRAM_CYCLES(PROG_C)) dut (
        .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
        .prot_en(prot_en), .so_q(so_q), .so_oe_q(so_oe_q), .busy_q(busy_q),
        .buf1_wr_q(buf1_wr_q), .buf1_addr_q(buf1_addr_q), .buf1_data_q(buf1_data_q),
        .sub0a_prot_q(sub0a_prot_q), .sub0b_prot_q(sub0b_prot_q), .sect_prot_q(sect_prot_q));
    spi_host host (.sck(sck), .cs_n(cs_n), .si(si), .so_q(so_q), .so_oe_q(so_oe_q));

    initial clock = 1'b0;
    always #20 clock = ~clock;

    // ***************************************************************
    // Monitor
    // ***************************************************************
    always @(posedge clock) begin
        if (busy_q === 1'b1) begin
            run       <= run + 1;
            busy_seen <= 1'b1;
        end else if (run != 0) begin
            last_run <= run;
            run      <= 0;
        end
        if (buf1_wr_q === 1'b1) begin
            wr_cnt  <= wr_cnt + 1;
            wr_addr <= buf1_addr_q;
            wr_data <= buf1_data_q;
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task chk_map(input logic [7:0] b0, input logic [7:0] odd, input logic [7:0] even);
        logic [7:0] m [17];
        host.rd(spm_pkg::OP_MAP_READ, 3, 17, m);
        chk({8'h00, m[0]}, {8'h00, b0});
        for (int k = 1; k < 16; k++) chk({8'h00, m[k]}, {8'h00, k[0] ? odd : even});
        chk({8'h00, m[16]}, {8'h00, spm_pkg::MAP_UNDEF_BYTE});
        chk({15'h0000, so_oe_q}, 16'h0000);
    endtask : chk_map

    // Bounded wait for the self-timed cycle to end, then its length
    task wait_idle(input int len);
        for (int n = 0; n < 1000 && busy_q !== 1'b0; n++) @(posedge clock);
        repeat (2) @(posedge clock);
        chk({15'h0000, busy_q}, 16'h0000);
        chk({15'h0000, last_run >= len - 1 && last_run <= len + 2}, 16'h0001);
    endtask : wait_idle

    task wrap_up();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #2000000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end

    // ***************************************************************
    // Sequence
    // ***************************************************************
    initial begin
        {error_cnt, tests_run, run, last_run, wr_cnt} = '0;
        {rst, wp_n, prot_en, busy_seen} = 4'h4;
        for (int k = 0; k < 16; k++) d[k] = k[0] ? 8'hFF : 8'h00;
        d[0]  = 8'h30;
        d[16] = 8'hC5;
        // A real rising edge is needed to clear the link's byte handoff
        @(posedge clock) rst <= 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        chk_map(8'h00, 8'h00, 8'h00);
        chk(sect_prot_q, 16'h0000);
        host.rd(spm_pkg::OP_STATUS_READ, 0, 1, r);
        chk({8'h00, r[0]}, 16'h0080);
        host.open_frame();
        host.put(spm_pkg::PREFIX_0, r[0]);
        host.put(spm_pkg::PREFIX_1, r[0]);
        host.close_frame();
        repeat (10) @(posedge clock);
        chk({15'h0000, busy_seen}, 16'h0000);
        // Erase first, and only a few rewrites in all
        prot_en <= 1'b1;
        host.map_cmd(spm_pkg::OP_MAP_ERASE, 0, d);
        chk({15'h0000, busy_q}, 16'h0001);
        wait_idle(ERASE_C);
        chk_map(8'hFF, 8'hFF, 8'hFF);
        chk(sect_prot_q, 16'hFFFF);
        chk({14'h0000, sub0a_prot_q, sub0b_prot_q}, 16'h0003);
        @(negedge clock) wr_cnt = 0;
        host.map_cmd(spm_pkg::OP_MAP_PROGRAM, 17, d);
        host.rd(spm_pkg::OP_STATUS_READ, 0, 1, r);
        chk({8'h00, r[0]}, 16'h0002);
        wait_idle(PROG_C);
        chk(16'(wr_cnt), 16'h0011);
        chk({4'h0, wr_addr, wr_data}, 16'h00C5);
        chk_map(8'hC5, 8'hFF, 8'h00);
        chk(sect_prot_q, 16'hAAAB);
        chk({14'h0000, sub0a_prot_q, sub0b_prot_q}, 16'h0002);
        @(posedge clock);
        prot_en <= 1'b0;
        wp_n    <= 1'b0;
        repeat (6) @(posedge clock);
        chk(sect_prot_q, 16'hAAAB);
        @(negedge clock) busy_seen = 1'b0;
        host.map_cmd(spm_pkg::OP_MAP_ERASE, 0, d);
        repeat (10) @(posedge clock);
        chk({15'h0000, busy_seen}, 16'h0000);
        chk_map(8'hC5, 8'hFF, 8'h00);
        @(posedge clock);
        wp_n <= 1'b1;
        repeat (6) @(posedge clock);
        chk(sect_prot_q, 16'h0000);
        wrap_up();
    end
endmodule : tb
